// ===== bench/lhc_core_model.sv
// Purpose: stand-in for the uart receive core that feeds the block
// Assumes: requests from the bench are one-cycle pulses
// Notes: each request comes back as a registered one-cycle event
`timescale 1ns/1ps
`default_nettype none

module lhc_core_model (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic char_req_i,
  input wire logic hdr_req_i,
  input wire logic resync_req_i,
  input wire logic [15:0] resync_val_i,
  output logic rx_char_done_o,
  output logic hdr_rx_done_o,
  output logic resync_valid_o,
  output logic [15:0] resync_div_o
);
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      rx_char_done_o <= 1'b0;
      hdr_rx_done_o <= 1'b0;
      resync_valid_o <= 1'b0;
      resync_div_o <= 16'h0000;
    end
    else
    begin
      rx_char_done_o <= char_req_i;
      hdr_rx_done_o <= hdr_req_i;
      resync_valid_o <= resync_req_i;
      // divider bus is junk outside its valid cycle
      resync_div_o <= resync_req_i ? resync_val_i : ~resync_div_o;
    end
  end
endmodule : lhc_core_model

`default_nettype wire

// ===== bench/lin_slave_header_control_tb_top.sv
// Purpose: self-checking bench for the LIN slave header control block
// Assumes: 200 MHz clock, synchronous active-high reset
// Notes: ready and answers are sampled at the falling edge before the taking edge
`timescale 1ns/1ps
`include "lhc_defs.svh"
`default_nettype none

module lin_slave_header_control_tb_top;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, baud_mode_o, head_sel_o;
  logic rx_char_done_i, hdr_rx_done_i, resync_valid_i;
  logic [15:0] resync_div_i, baud_div_o;
  logic hdr_tx_start_o, hdr_tx_busy_o, bit_tick_o, mute_en_o, slave_en_o;
  logic auto_resync_en_o, hdr_detect_en_o, irq_o;
  logic char_req = 1'b0, hdr_req = 1'b0, res_req = 1'b0;
  logic [15:0] res_val = 16'h0000;
  int failures = 0, compares = 0, cycles = 0, tick_cnt = 0, start_cnt = 0;

  lhc_top lhc_top_inst (
    .mclk_i, .srst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_char_done_i, .hdr_rx_done_i,
    .resync_valid_i, .resync_div_i, .baud_div_o, .baud_mode_o, .head_sel_o,
    .hdr_tx_start_o, .hdr_tx_busy_o, .bit_tick_o, .mute_en_o, .slave_en_o,
    .auto_resync_en_o, .hdr_detect_en_o, .irq_o
  );

  lhc_core_model lhc_core_model_inst (
    .mclk_i(mclk_i), .srst_i(srst_i), .char_req_i(char_req), .hdr_req_i(hdr_req),
    .resync_req_i(res_req), .resync_val_i(res_val), .rx_char_done_o(rx_char_done_i),
    .hdr_rx_done_o(hdr_rx_done_i), .resync_valid_o(resync_valid_i),
    .resync_div_o(resync_div_i)
  );

  always #2.5 mclk_i = ~mclk_i;

  always @(negedge mclk_i)
  begin
    if (hdr_tx_busy_o === 1'b1 && bit_tick_o === 1'b1)
      tick_cnt++;
    if (hdr_tx_start_o === 1'b1)
      start_cnt++;
  end

  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hs, w_hs, done;
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      @(negedge mclk_i);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      done = (s_axi_bvalid === 1'b1);
      r = s_axi_bresp;
      @(posedge mclk_i);
      if (aw_hs)
        s_axi_awvalid <= 1'b0;
      if (w_hs)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(negedge mclk_i);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, done;
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      @(negedge mclk_i);
      ar_hs = s_axi_arvalid && s_axi_arready;
      done = (s_axi_rvalid === 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk_i);
      if (ar_hs)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(negedge mclk_i);
  endtask : axi_rd

  task automatic core_ev(input logic c, input logic h, input logic rs, input logic [15:0] v);
    @(posedge mclk_i);
    char_req <= c;
    hdr_req <= h;
    res_req <= rs;
    res_val <= v;
    @(posedge mclk_i);
    char_req <= 1'b0;
    hdr_req <= 1'b0;
    res_req <= 1'b0;
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : core_ev

  task automatic sc_reset_values;
    logic [7:0] ofs [6] = '{`LHC_OFS_IER, `LHC_OFS_BAUD, `LHC_OFS_ALT, `LHC_OFS_FUNC,
                            `LHC_OFS_CTL, `LHC_OFS_STAT};
    logic [31:0] d;
    logic [1:0] r;
    foreach (ofs[i])
    begin
      axi_rd(ofs[i], d, r);
      chk(d, `LHC_RST_WORD);
      chk(32'(r), 32'(`LHC_RESP_OKAY));
    end
    axi_rd(8'h3C, d, r);
    chk(d, 32'h0000_0000);
    chk(32'(r), 32'(`LHC_RESP_SLVERR));
    axi_wr(8'h3C, 32'hFFFF_FFFF, r);
    chk(32'(r), 32'(`LHC_RESP_SLVERR));
  endtask : sc_reset_values

  task automatic sc_gating;
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(`LHC_OFS_CTL, 32'h0000_001F, r);
    chk(32'({mute_en_o, hdr_detect_en_o, auto_resync_en_o, slave_en_o}), 32'h0);
    axi_wr(`LHC_OFS_FUNC, 32'(`LHC_FUNC_BUS), r);
    chk(32'({mute_en_o, hdr_detect_en_o, auto_resync_en_o, slave_en_o}), 32'hF);
    axi_wr(`LHC_OFS_CTL, 32'h0000_001E, r);
    chk(32'({mute_en_o, hdr_detect_en_o, auto_resync_en_o, slave_en_o}), 32'h8);
    axi_rd(`LHC_OFS_CTL, d, r);
    chk(d, 32'h0000_001E);
    axi_wr(`LHC_OFS_CTL, 32'h0000_0004, r);
    chk(32'({mute_en_o, auto_resync_en_o}), 32'h0);
    // start a header, then abort it through the alternate view
    axi_wr(`LHC_OFS_CTL, 32'h0000_0100, r);
    chk(32'(hdr_tx_busy_o), 32'h1);
    axi_wr(`LHC_OFS_ALT, 32'h0000_0000, r);
    chk(32'(hdr_tx_busy_o), 32'h0);
    axi_rd(`LHC_OFS_CTL, d, r);
    chk(d, 32'h0000_0000);
  endtask : sc_gating

  task automatic sc_header(input lhc_pkg::lhc_head_sel_t sel, input logic use_alt, input int n);
    logic [31:0] d;
    logic [1:0] r;
    int k;
    tick_cnt = 0;
    start_cnt = 0;
    if (use_alt)
    begin
      axi_wr(`LHC_OFS_CTL, {8'h00, sel, 22'h0}, r);
      axi_wr(`LHC_OFS_ALT, 32'h0000_0080, r);
    end
    else
      axi_wr(`LHC_OFS_CTL, {8'h00, sel, 13'h0, 1'b1, 8'h00}, r);
    axi_rd(`LHC_OFS_CTL, d, r);
    chk(32'(d[`LHC_CTL_SHD]), 32'h1);
    axi_rd(`LHC_OFS_ALT, d, r);
    chk(32'(d[`LHC_ALT_SHD]), 32'h1);
    chk(32'(head_sel_o), 32'(sel));
    k = 0;
    while (hdr_tx_busy_o === 1'b1 && k < 200)
    begin
      @(negedge mclk_i);
      k++;
    end
    chk(32'(tick_cnt), 32'(n));
    chk(32'(start_cnt), 32'h1);
    axi_rd(`LHC_OFS_CTL, d, r);
    chk(d, {8'h00, sel, 22'h0});
    axi_rd(`LHC_OFS_ALT, d, r);
    chk(d, 32'h0000_0000);
  endtask : sc_header

  task automatic sc_divider;
    logic [1:0] r;
    axi_wr(`LHC_OFS_CTL, 32'h0000_0005, r);
    axi_wr(`LHC_OFS_BAUD, 32'h3000_0010, r);
    chk(32'(baud_div_o), 32'h0000_0010);
    chk(32'(baud_mode_o), 32'h3);
    core_ev(1'b0, 1'b0, 1'b1, 16'h0022);
    chk(32'(baud_div_o), 32'h0000_0022);
    axi_wr(`LHC_OFS_CTL, 32'h0000_000D, r);
    axi_wr(`LHC_OFS_BAUD, 32'h3000_0030, r);
    chk(32'(baud_div_o), 32'h0000_0022);
    core_ev(1'b1, 1'b0, 1'b0, 16'h0000);
    chk(32'(baud_div_o), 32'h0000_0030);
    axi_wr(`LHC_OFS_CTL, 32'h0000_000C, r);
    axi_wr(`LHC_OFS_BAUD, 32'h3000_0040, r);
    chk(32'(baud_div_o), 32'h0000_0040);
    core_ev(1'b0, 1'b0, 1'b1, 16'h0055);
    chk(32'(baud_div_o), 32'h0000_0040);
    axi_wr(`LHC_OFS_CTL, 32'h0000_0000, r);
  endtask : sc_divider

  task automatic sc_detect;
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(`LHC_OFS_IER, 32'h0000_0100, r);
    axi_wr(`LHC_OFS_CTL, 32'h0000_0003, r);
    chk(32'(irq_o), 32'h0);
    core_ev(1'b0, 1'b1, 1'b0, 16'h0000);
    axi_rd(`LHC_OFS_STAT, d, r);
    chk(d, 32'h0000_0001);
    chk(32'(irq_o), 32'h1);
    axi_wr(`LHC_OFS_IER, 32'h0000_0000, r);
    chk(32'(irq_o), 32'h0);
    axi_wr(`LHC_OFS_STAT, 32'h0000_0001, r);
    axi_rd(`LHC_OFS_STAT, d, r);
    chk(d, 32'h0000_0000);
    axi_wr(`LHC_OFS_IER, 32'h0000_0100, r);
    axi_wr(`LHC_OFS_CTL, 32'h0000_0001, r);
    core_ev(1'b0, 1'b1, 1'b0, 16'h0000);
    axi_rd(`LHC_OFS_STAT, d, r);
    chk(d, 32'h0000_0000);
    chk(32'(irq_o), 32'h0);
  endtask : sc_detect

  initial
  begin
    repeat (4) @(posedge mclk_i);
    srst_i <= 1'b0;
    sc_reset_values();
    sc_gating();
    sc_header(lhc_pkg::HS_BREAK, 1'b0, `LHC_BITS_BREAK);
    sc_header(lhc_pkg::HS_BREAK_SYNC, 1'b1, `LHC_BITS_SYNC);
    sc_header(lhc_pkg::HS_FULL, 1'b0, `LHC_BITS_FULL);
    sc_divider();
    sc_detect();
    give_verdict();
  end
endmodule : lin_slave_header_control_tb_top

`default_nettype wire

// ===== rtl/lhc_defs.svh
// Purpose: constants of the LIN slave header control block
// Assumes: byte addresses on a 32-bit AXI4-Lite register bus
// Notes: definitions only
`ifndef LHC_DEFS_SVH
`define LHC_DEFS_SVH

// register byte offsets
`define LHC_OFS_IER 8'h04
`define LHC_OFS_BAUD 8'h24
`define LHC_OFS_ALT 8'h2C
`define LHC_OFS_FUNC 8'h30
`define LHC_OFS_CTL 8'h34
`define LHC_OFS_STAT 8'h38

// control register fields
`define LHC_CTL_SLAVE 0
`define LHC_CTL_HDET 1
`define LHC_CTL_ARS 2
`define LHC_CTL_DUM 3
`define LHC_CTL_MUTE 4
`define LHC_CTL_SHD 8
`define LHC_CTL_HSEL_LO 22
`define LHC_CTL_HSEL_HI 23

// alternate control, status, irq enable, baud fields
`define LHC_ALT_SHD 7
`define LHC_STAT_HDET 0
`define LHC_IER_BUS 8
`define LHC_BAUD_DIV_HI 15
`define LHC_BAUD_MODE_LO 28
`define LHC_BAUD_MODE_HI 29

// function select encoding for the bus function
`define LHC_FUNC_BUS 2'h1

// reset values
`define LHC_RST_WORD 32'h0000_0000
`define LHC_RST_DIV 16'h0000
`define LHC_RST_HSEL 2'h0
`define LHC_RST_FUNC 2'h0

// header lengths in bit times: break+delimiter, +sync, +frame id
`define LHC_BITS_BREAK 6'd14
`define LHC_BITS_SYNC 6'd24
`define LHC_BITS_FULL 6'd34

// axi responses
`define LHC_RESP_OKAY 2'h0
`define LHC_RESP_SLVERR 2'h2

`endif

// ===== rtl/lhc_hdr_tx.sv
// Purpose: times one header transmission in bit ticks
// Assumes: bit_tick_i is a one-cycle pulse per bit time
// Notes: done_o is combinational, high in the last cycle of the run
`timescale 1ns/1ps
`include "lhc_defs.svh"
`default_nettype none

module lhc_hdr_tx (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [1:0] head_sel_i,
  input wire logic bit_tick_i,
  output logic busy_o,
  output logic done_o
);

  lhc_pkg::lhc_tx_state_t state_reg;
  lhc_pkg::lhc_tx_state_t state_next;
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic [5:0] len_reg;
  logic [5:0] len_next;
  logic last_w;

  function automatic logic [5:0] hdr_len(input logic [1:0] sel);
    case (sel)
      lhc_pkg::HS_BREAK: hdr_len = `LHC_BITS_BREAK;
      lhc_pkg::HS_BREAK_SYNC: hdr_len = `LHC_BITS_SYNC;
      default: hdr_len = `LHC_BITS_FULL;
    endcase
  endfunction : hdr_len

  assign last_w = bit_tick_i && (cnt_reg == len_reg - 6'd1);
  assign busy_o = (state_reg == lhc_pkg::TX_RUN);
  assign done_o = busy_o && last_w && !abort_i;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    len_next = len_reg;
    case (state_reg)
      lhc_pkg::TX_IDLE:
      begin
        if (start_i)
        begin
          state_next = lhc_pkg::TX_RUN;
          cnt_next = 6'd0;
          len_next = hdr_len(head_sel_i);
        end
      end
      lhc_pkg::TX_RUN:
      begin
        if (abort_i || last_w)
        begin
          state_next = lhc_pkg::TX_IDLE;
        end
        else if (bit_tick_i)
        begin
          cnt_next = cnt_reg + 6'd1;
        end
      end
      default: state_next = lhc_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      state_reg <= lhc_pkg::TX_IDLE;
      cnt_reg <= 6'd0;
      len_reg <= `LHC_BITS_FULL;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      len_reg <= len_next;
    end
  end

endmodule : lhc_hdr_tx

`default_nettype wire

// ===== rtl/lhc_pkg.sv
// Purpose: types of the LIN slave header control block
// Assumes: constants live in lhc_defs.svh
// Notes: nothing here is imported; users write lhc_pkg::name
package lhc_pkg;

  typedef enum logic [1:0] {
    HS_BREAK = 2'b00,
    HS_BREAK_SYNC = 2'b01,
    HS_FULL = 2'b10
  } lhc_head_sel_t;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_RUN = 1'b1
  } lhc_tx_state_t;

endpackage : lhc_pkg

// ===== rtl/lhc_top.sv
// Purpose: LIN slave header control registers behind an AXI4-Lite slave
// Assumes: uart core inputs are synchronous one-cycle pulses
// Notes: unmapped addresses answer SLVERR and read zero
// Functional notes
// - header send request clears itself when the selected header is sent
// - send request is one bit, seen in both alternate and main control
// - control bit 4 turns mute mode on or off while the bus function is selected
// - method bit clear: divider takes written value unless resync updates it
// - method bit set: divider write waits for the next received character
// - control bit 2 turns slave automatic resync on or off
// - method, resync and header detect act only in slave mode
// - detect enabled: full header received sets the detected flag
// - detected flag with bus irq enable raises the interrupt
// - control bit 0 turns slave mode on or off while the bus function is selected
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "lhc_defs.svh"
`default_nettype none

module lhc_top (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_char_done_i,
  input wire logic hdr_rx_done_i,
  input wire logic resync_valid_i,
  input wire logic [15:0] resync_div_i,
  output logic [15:0] baud_div_o,
  output logic [1:0] baud_mode_o,
  output logic [1:0] head_sel_o,
  output logic hdr_tx_start_o,
  output logic hdr_tx_busy_o,
  output logic bit_tick_o,
  output logic mute_en_o,
  output logic slave_en_o,
  output logic auto_resync_en_o,
  output logic hdr_detect_en_o,
  output logic irq_o
);

  // axi slave state
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // register fields
  logic slave_reg;
  logic hdet_en_reg;
  logic ars_reg;
  logic dum_reg;
  logic mute_reg;
  logic shd_reg;
  logic shd_next;
  logic [1:0] hsel_reg;
  logic [1:0] func_reg;
  logic ier_bus_reg;
  logic hdet_flag_reg;
  logic hdet_flag_next;
  logic [15:0] div_reg;
  logic [1:0] mode_reg;
  logic pend_v_reg;
  logic [15:0] pend_div_reg;
  logic [15:0] tick_cnt_reg;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    integer i;
    merge = old_v;
    for (i = 0; i < 4; i = i + 1)
    begin
      if (strb[i])
      begin
        merge[8*i +: 8] = new_v[8*i +: 8];
      end
    end
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `LHC_OFS_IER) || (a == `LHC_OFS_BAUD) || (a == `LHC_OFS_ALT) ||
             (a == `LHC_OFS_FUNC) || (a == `LHC_OFS_CTL) || (a == `LHC_OFS_STAT);
  endfunction : mapped

  // register views
  wire [31:0] ctl_view = {8'h00, hsel_reg, 13'h0000, shd_reg, 3'h0, mute_reg, dum_reg,
                          ars_reg, hdet_en_reg, slave_reg};
  wire [31:0] alt_view = {24'h00_0000, shd_reg, 7'h00};
  wire [31:0] baud_view = {2'h0, mode_reg, 12'h000, div_reg};
  wire [31:0] stat_view = {31'h0000_0000, hdet_flag_reg};
  wire [31:0] ier_view = {23'h00_0000, ier_bus_reg, 8'h00};
  wire [31:0] func_view = {30'h0000_0000, func_reg};

  // write decode
  wire wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire ctl_wr = wr_fire && (awaddr_reg == `LHC_OFS_CTL);
  wire alt_wr = wr_fire && (awaddr_reg == `LHC_OFS_ALT);
  wire baud_wr = wr_fire && (awaddr_reg == `LHC_OFS_BAUD);
  wire stat_wr = wr_fire && (awaddr_reg == `LHC_OFS_STAT);
  wire ier_wr = wr_fire && (awaddr_reg == `LHC_OFS_IER);
  wire func_wr = wr_fire && (awaddr_reg == `LHC_OFS_FUNC);
  wire [31:0] ctl_m = merge(ctl_view, wdata_reg, wstrb_reg);
  wire [31:0] alt_m = merge(alt_view, wdata_reg, wstrb_reg);
  wire [31:0] baud_m = merge(baud_view, wdata_reg, wstrb_reg);
  wire [31:0] ier_m = merge(ier_view, wdata_reg, wstrb_reg);
  wire [31:0] func_m = merge(func_view, wdata_reg, wstrb_reg);

  // read decode
  wire rd_fire = s_axi_arvalid && !rvalid_reg;
  wire [31:0] rd_val = (s_axi_araddr == `LHC_OFS_CTL) ? ctl_view :
                       (s_axi_araddr == `LHC_OFS_ALT) ? alt_view :
                       (s_axi_araddr == `LHC_OFS_BAUD) ? baud_view :
                       (s_axi_araddr == `LHC_OFS_STAT) ? stat_view :
                       (s_axi_araddr == `LHC_OFS_IER) ? ier_view :
                       (s_axi_araddr == `LHC_OFS_FUNC) ? func_view : `LHC_RST_WORD;

  // effective enables
  wire bus_on = (func_reg == `LHC_FUNC_BUS);
  wire slave_eff = slave_reg && bus_on;
  wire ars_eff = slave_eff && ars_reg;
  wire dum_eff = slave_eff && dum_reg;
  wire hdet_eff = slave_eff && hdet_en_reg;
  wire resync_upd = ars_eff && resync_valid_i;

  // header send request, one bit shared by two views
  wire tx_done;
  wire sw_shd_set = (ctl_wr && ctl_m[`LHC_CTL_SHD]) || (alt_wr && alt_m[`LHC_ALT_SHD]);
  wire sw_shd_clr = (ctl_wr && !ctl_m[`LHC_CTL_SHD]) || (alt_wr && !alt_m[`LHC_ALT_SHD]);
  // abort on the clearing write itself, so busy drops at the same edge as the request
  wire shd_abort = !shd_reg || sw_shd_clr;
  assign shd_next = sw_shd_set || (shd_reg && !tx_done && !sw_shd_clr);
  assign hdr_tx_start_o = shd_reg && !hdr_tx_busy_o && !sw_shd_clr;
  assign hdet_flag_next = (hdr_rx_done_i && hdet_eff) ||
                          (hdet_flag_reg && !(stat_wr && wstrb_reg[0] &&
                                              wdata_reg[`LHC_STAT_HDET]));
  assign bit_tick_o = (tick_cnt_reg == 16'h0000);

  lhc_hdr_tx u_hdr_tx (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .start_i(hdr_tx_start_o),
    .abort_i(shd_abort),
    .head_sel_i(hsel_reg),
    .bit_tick_i(bit_tick_o),
    .busy_o(hdr_tx_busy_o),
    .done_o(tx_done)
  );

  // axi handshake
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= `LHC_RST_WORD;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `LHC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(awaddr_reg) ? `LHC_RESP_OKAY : `LHC_RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= `LHC_RST_WORD;
      rresp_reg <= `LHC_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_val;
      rresp_reg <= mapped(s_axi_araddr) ? `LHC_RESP_OKAY : `LHC_RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  // control, status and irq enable
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      slave_reg <= 1'b0;
      hdet_en_reg <= 1'b0;
      ars_reg <= 1'b0;
      dum_reg <= 1'b0;
      mute_reg <= 1'b0;
      shd_reg <= 1'b0;
      hsel_reg <= `LHC_RST_HSEL;
      func_reg <= `LHC_RST_FUNC;
      ier_bus_reg <= 1'b0;
      hdet_flag_reg <= 1'b0;
    end
    else
    begin
      shd_reg <= shd_next;
      hdet_flag_reg <= hdet_flag_next;
      if (ctl_wr)
      begin
        slave_reg <= ctl_m[`LHC_CTL_SLAVE];
        hdet_en_reg <= ctl_m[`LHC_CTL_HDET];
        ars_reg <= ctl_m[`LHC_CTL_ARS];
        dum_reg <= ctl_m[`LHC_CTL_DUM];
        mute_reg <= ctl_m[`LHC_CTL_MUTE];
        hsel_reg <= ctl_m[`LHC_CTL_HSEL_HI:`LHC_CTL_HSEL_LO];
      end
      if (ier_wr)
      begin
        ier_bus_reg <= ier_m[`LHC_IER_BUS];
      end
      if (func_wr)
      begin
        func_reg <= func_m[1:0];
      end
    end
  end

  // baud divider with deferred update
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      div_reg <= `LHC_RST_DIV;
      mode_reg <= 2'h0;
      pend_v_reg <= 1'b0;
      pend_div_reg <= `LHC_RST_DIV;
      tick_cnt_reg <= `LHC_RST_DIV;
    end
    else
    begin
      tick_cnt_reg <= bit_tick_o ? div_reg : tick_cnt_reg - 16'h0001;
      if (baud_wr)
      begin
        mode_reg <= baud_m[`LHC_BAUD_MODE_HI:`LHC_BAUD_MODE_LO];
      end
      if (resync_upd)
      begin
        div_reg <= resync_div_i;
      end
      else if (baud_wr && !dum_eff)
      begin
        div_reg <= baud_m[`LHC_BAUD_DIV_HI:0];
      end
      else if (pend_v_reg && rx_char_done_i)
      begin
        div_reg <= pend_div_reg;
      end
      if (baud_wr && dum_eff)
      begin
        pend_v_reg <= 1'b1;
        pend_div_reg <= baud_m[`LHC_BAUD_DIV_HI:0];
      end
      else if (pend_v_reg && rx_char_done_i && !resync_upd)
      begin
        pend_v_reg <= 1'b0;
      end
    end
  end

  assign baud_div_o = div_reg;
  assign baud_mode_o = mode_reg;
  assign head_sel_o = hsel_reg;
  assign mute_en_o = mute_reg && bus_on;
  assign slave_en_o = slave_eff;
  assign auto_resync_en_o = ars_eff;
  assign hdr_detect_en_o = hdet_eff;
  assign irq_o = hdet_flag_reg && ier_bus_reg;

  property p_shd_self_clear;
    @(posedge mclk_i) disable iff (srst_i)
    (tx_done && !sw_shd_set) |=> (!shd_reg && !hdr_tx_busy_o);
  endproperty
  a_shd_self_clear: assert property (p_shd_self_clear) else $error("send request not cleared");

  property p_alt_sets_shd;
    @(posedge mclk_i) disable iff (srst_i)
    (alt_wr && wstrb_reg[0] && wdata_reg[7]) |=> shd_reg ##1 hdr_tx_busy_o;
  endproperty
  a_alt_sets_shd: assert property (p_alt_sets_shd) else $error("alternate view did not set");

  property p_mute;
    @(posedge mclk_i) disable iff (srst_i)
    (ctl_wr && wstrb_reg[0] && bus_on) |=> (mute_en_o == $past(wdata_reg[4]));
  endproperty
  a_mute: assert property (p_mute) else $error("mute enable wrong");

  property p_div_direct;
    @(posedge mclk_i) disable iff (srst_i)
    (baud_wr && (wstrb_reg[1:0] == 2'h3) && !dum_eff && !resync_upd)
      |=> (baud_div_o == $past(wdata_reg[15:0]));
  endproperty
  a_div_direct: assert property (p_div_direct) else $error("divider not written");

  property p_div_defer;
    @(posedge mclk_i) disable iff (srst_i)
    (baud_wr && dum_eff && !resync_upd && !rx_char_done_i) |=> $stable(baud_div_o);
  endproperty
  a_div_defer: assert property (p_div_defer) else $error("deferred divider changed");

  property p_slave_gate;
    @(posedge mclk_i) disable iff (srst_i)
    !slave_en_o |-> (!auto_resync_en_o && !hdr_detect_en_o && !dum_eff);
  endproperty
  a_slave_gate: assert property (p_slave_gate) else $error("slave gating broken");

  property p_hdet_set;
    @(posedge mclk_i) disable iff (srst_i)
    (hdr_rx_done_i && hdr_detect_en_o) |=> hdet_flag_reg;
  endproperty
  a_hdet_set: assert property (p_hdet_set) else $error("header flag not set");

  property p_irq;
    @(posedge mclk_i) disable iff (srst_i)
    (hdr_rx_done_i && hdr_detect_en_o && ier_bus_reg && !ier_wr) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_busy_reads_one;
    @(posedge mclk_i) disable iff (srst_i)
    hdr_tx_busy_o |-> (shd_reg && ctl_view[8] && alt_view[7]);
  endproperty
  a_busy_reads_one: assert property (p_busy_reads_one) else $error("busy but request low");

endmodule : lhc_top

`default_nettype wire
